// >>> hw/pwm3_pkg.sv
/*
 * Constants for the three-phase PWM block: register offsets, field
 * positions, reset values, mode codes and count-clock timing.
 * Assumes a 32-bit APB register bus and one clock domain.
 */
package pwm3_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int VAL_W = 16;
    localparam int CNT_W = VAL_W + 1;
    localparam int PHASES = 3;
    localparam int ADCS = 2;
    localparam int INT_W = 3;
    localparam int ADC_TIMING_W = 6;
    localparam int OPTION_W = 8;

    // Count clock is the peripheral clock divided by this figure.
    localparam int PRESCALE_DIV = 2;

    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DEAD = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_OPTION = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_SET_FIRST = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_SET_SECOND = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_SET_THIRD = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_TRIG0 = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_TRIG1 = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_ADC_TIMING = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_INT_ENABLE = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_INT_CLEAR = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_STATE = 8'h34;
    localparam logic [ADDR_W-1:0] OFS_CMP_U = 8'h38;
    localparam logic [ADDR_W-1:0] OFS_CMP_V = 8'h3C;
    localparam logic [ADDR_W-1:0] OFS_CMP_W = 8'h40;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_OE_BIT = 2;
    localparam int INT_VALLEY_BIT = 0;
    localparam int INT_TRIG0_BIT = 1;
    localparam int STATE_DIR_BIT = 17;
    localparam int STATE_PEND_BIT = 18;

    localparam logic [1:0] MODE_DIRECT = 2'h0;
    localparam logic [1:0] MODE_DQ = 2'h1;
    localparam logic [1:0] MODE_LOCK = 2'h2;

    localparam logic [VAL_W-1:0] RST_PERIOD = 16'h031F;
    localparam logic [VAL_W-1:0] RST_DEAD = 16'h0080;
    localparam logic [VAL_W-1:0] RST_TRIG = 16'h0020;
    localparam logic [ADC_TIMING_W-1:0] RST_ADC_TIMING = 6'h00;
endpackage

// >>> hw/phase_if.sv
/*
 * Link between the carrier logic and one phase's dead-time stage.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface phase_if import pwm3_pkg::*; ();
    logic tick;
    logic raw;
    logic [VAL_W-1:0] dead;
    logic upper;
    logic lower_act;
    modport gen(output tick, output raw, output dead,
                input upper, input lower_act);
    modport arm(input tick, input raw, input dead,
                output upper, output lower_act);
endinterface
`default_nettype wire

// >>> hw/dead_time_arm.sv
/*
 * Dead-time stage for one phase: turns the raw compare level into
 * upper and lower arm drive with a gap around every transition.
 * Assumes tick is a one-cycle count-clock strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module dead_time_arm import pwm3_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_b,
    phase_if.arm link
);
    logic raw_q;
    logic [VAL_W-1:0] gap;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            raw_q <= 1'b0;
            gap <= '0;
        end else if (link.tick) begin
            raw_q <= link.raw;
            if (link.raw != raw_q) begin
                gap <= link.dead; // [R15]
            end else if (gap != '0) begin
                gap <= gap - 1'b1;
            end
        end
    end

    // The gap delays each turn-on, so both arms are off meanwhile.
    assign link.upper = raw_q && (gap == '0); // [R1] [R18]
    assign link.lower_act = !raw_q && (gap == '0); // [R2] [R18]
endmodule
`default_nettype wire

// >>> hw/three_phase_pwm.sv
/*
 * Three-phase complementary PWM generator with dead time, batch
 * reload at the carrier valley and two A/D start triggers, with an
 * APB register slave and a level interrupt.
 * Assumes a single clock, an APB master with 32-bit data and a gate
 * driver that reads high impedance when the enables are low.
 */
// Local design decisions: register access over APB and the placing of the registers.
// Operation
// (R1) Upper width is twice span minus dead.
// (R2) Lower inactive width is twice span plus dead.
// (R3) Three phase compares, one each U, V, W.
// (R4) Trigger n fires after its compare count.
// (R5) Trigger timer steps on PWM count clock.
// (R6) Trigger delay measured from carrier valley.
// (R7) Software sets both trigger compares equal.
// (R8) Software sets conversion timing field to 0x0C.
// (R9) Mode codes: direct, dq, output lock.
// (R10) Output enable: high impedance or PWM drive.
// (R11) Direct widths range zero to period plus one.
// (R12) Software keeps d, q, angle in range.
// (R13) Count clock is two peripheral clocks.
// (R14) Carrier is up-down, twice period plus one.
// (R15) Dead time is count times count clock.
// (R16) First set write arms valley batch reload.
// (R17) Output lock keeps previous phase duties.
// (R18) Arms complementary, both off during dead time.
`timescale 1ns/1ps
`default_nettype none
module three_phase_pwm import pwm3_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [DATA_W-1:0] i_pwdata,
    output logic [DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [PHASES-1:0] o_pwm_upper,
    output logic [PHASES-1:0] o_pwm_lower_n,
    output logic [2*PHASES-1:0] o_pwm_oe,
    output logic [ADCS-1:0] o_adc_start,
    output logic [ADC_TIMING_W-1:0] o_adc_conv_timing,
    output logic o_carrier_valley,
    output logic o_irq
);
    // Software-facing registers.
    logic [1:0] mode;
    logic out_en;
    logic [VAL_W-1:0] period_sh;
    logic [VAL_W-1:0] dead_sh;
    logic [OPTION_W-1:0] option_sh;
    logic [VAL_W-1:0] set_value [PHASES];
    logic [VAL_W-1:0] trig_sh [ADCS];
    logic [ADC_TIMING_W-1:0] adc_timing;
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_enable;
    logic reload_pending;
    // Values in force for the running carrier.
    logic [VAL_W-1:0] carrier_period_value;
    logic [VAL_W-1:0] dead_time_count;
    logic [OPTION_W-1:0] pwm_option_setting;
    logic [CNT_W-1:0] phase_compare [PHASES];
    logic [VAL_W-1:0] trig_cmp [ADCS];
    // Carrier and trigger timer state.
    logic [$clog2(PRESCALE_DIV)-1:0] presc;
    logic tick;
    logic [CNT_W-1:0] cnt;
    logic dir_up;
    logic valley;
    logic step;
    logic [VAL_W-1:0] elapsed;
    logic [ADCS-1:0] armed;
    logic [ADCS-1:0] fire;
    // Phase drive.
    logic [PHASES-1:0] raw;
    logic [PHASES-1:0] upper;
    logic [PHASES-1:0] lower_act;
    // Bus decode.
    logic access;
    logic wr_en;
    logic hit;
    logic [DATA_W-1:0] rd_value;
    logic set_first_wr;
    // Maps a set value to a compare count, clamped to the carrier top.
    function automatic logic [CNT_W-1:0] to_compare(
        input logic [1:0] m,
        input logic [VAL_W-1:0] val,
        input logic [VAL_W-1:0] per
    );
        logic signed [CNT_W+1:0] top;
        logic signed [CNT_W+1:0] base;
        logic signed [CNT_W+1:0] res;
        top = $signed({3'h0, per}) + 19'sh00001;
        base = (m == MODE_DQ) ? (top >>> 1) : top;
        res = base - $signed({{3{val[VAL_W-1]}}, val});
        if (res < 0) begin
            res = '0;
        end else if (res > top) begin
            res = top;
        end
        return res[CNT_W-1:0];
    endfunction
    // Count-clock strobe, one clock in every PRESCALE_DIV.
    always_ff @(posedge i_clk or negedge i_rst_b) begin // [R13]
        if (!i_rst_b) begin
            presc <= '0;
        end else if (tick) begin
            presc <= '0;
        end else begin
            presc <= presc + 1'b1;
        end
    end
    assign tick = (presc == PRESCALE_DIV[$clog2(PRESCALE_DIV)-1:0] - 1'b1);
    // The valley is the down-count reaching zero.
    assign valley = tick && !dir_up && (cnt <= {{(CNT_W-1){1'b0}}, 1'b1});
    // Triangular carrier: 0..P counting up, P+1..1 counting down.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt <= '0;
            dir_up <= 1'b1;
        end else if (tick) begin
            if (dir_up) begin
                if (cnt >= {1'b0, carrier_period_value}) begin
                    cnt <= {1'b0, carrier_period_value} + 1'b1; // [R14]
                    dir_up <= 1'b0;
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end else if (valley) begin
                cnt <= '0; // [R14]
                dir_up <= 1'b1;
            end else begin
                cnt <= cnt - 1'b1;
            end
        end
    end
    // Up and down thresholds differ by one so each phase gets an
    // exact 2*(P+1-C) count-clock raw window.
    always_comb begin
        for (int p = 0; p < PHASES; p++) begin
            raw[p] = dir_up ? (cnt >= phase_compare[p])
                            : (cnt > phase_compare[p]); // [R1] [R2]
        end
    end
    // Batch reload: period, dead time, option, triggers and, outside lock mode, duties change together at a valley.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            carrier_period_value <= RST_PERIOD;
            dead_time_count <= RST_DEAD;
            pwm_option_setting <= '0;
            for (int a = 0; a < ADCS; a++) begin
                trig_cmp[a] <= RST_TRIG;
            end
            for (int p = 0; p < PHASES; p++) begin
                phase_compare[p] <= {1'b0, RST_PERIOD} + 1'b1;
            end
        end else if (valley && reload_pending) begin
            carrier_period_value <= period_sh; // [R16]
            dead_time_count <= dead_sh;
            pwm_option_setting <= option_sh;
            for (int a = 0; a < ADCS; a++) begin
                trig_cmp[a] <= trig_sh[a];
            end
            // In lock mode the applied duties stay as they were.
            if (mode != MODE_LOCK) begin // [R17]
                for (int p = 0; p < PHASES; p++) begin
                    phase_compare[p] <= to_compare(mode, set_value[p],
                                                   period_sh); // [R3] [R9]
                end
            end
        end
    end
    // A write landing on the valley re-arms; the set wins the clear.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            reload_pending <= 1'b0;
        end else if (set_first_wr) begin
            reload_pending <= 1'b1; // [R16]
        end else if (valley) begin
            reload_pending <= 1'b0;
        end
    end
    // Trigger timer runs on the count clock, restarted by the valley.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            elapsed <= '0;
            step <= 1'b0;
        end else begin
            step <= tick; // [R5]
            if (valley) begin
                elapsed <= '0; // [R6]
            end else if (tick && (elapsed != {VAL_W{1'b1}})) begin
                elapsed <= elapsed + 1'b1;
            end
        end
    end
    always_comb begin
        for (int a = 0; a < ADCS; a++) begin
            fire[a] = step && armed[a] && (elapsed == trig_cmp[a]); // [R4]
        end
    end
    // Each trigger fires at most once per carrier period.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            armed <= '0;
            o_adc_start <= '0;
        end else begin
            o_adc_start <= fire;
            for (int a = 0; a < ADCS; a++) begin
                if (valley) begin
                    armed[a] <= 1'b1; // [R6]
                end else if (fire[a]) begin
                    armed[a] <= 1'b0;
                end
            end
        end
    end
    // Dead-time stages, one per phase.
    for (genvar g = 0; g < PHASES; g++) begin : g_phase
        phase_if link();
        assign link.tick = tick;
        assign link.raw = raw[g];
        assign link.dead = dead_time_count;
        assign upper[g] = link.upper;
        assign lower_act[g] = link.lower_act;
        dead_time_arm u_arm (
            .i_clk(i_clk),
            .i_rst_b(i_rst_b),
            .link(link)
        );
    end
    // Pins are registered; a disabled output floats and drives zero.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pwm_upper <= '0;
            o_pwm_lower_n <= '0;
            o_pwm_oe <= '0;
            o_carrier_valley <= 1'b0;
        end else begin
            o_pwm_upper <= out_en ? upper : '0; // [R10] [R18]
            o_pwm_lower_n <= out_en ? ~lower_act : '0; // [R10] [R18]
            o_pwm_oe <= {(2*PHASES){out_en}}; // [R10]
            o_carrier_valley <= valley;
        end
    end
    // APB slave: zero wait states, read data captured in setup.
    assign access = i_psel && i_penable;
    assign wr_en = access && i_pwrite && hit;
    assign set_first_wr = wr_en && (i_paddr == OFS_SET_FIRST);
    assign o_pready = 1'b1;
    assign o_pslverr = access && !hit;
    always_comb begin
        hit = 1'b1;
        rd_value = '0;
        if (i_paddr == OFS_CTRL) begin
            rd_value[CTRL_MODE_LSB +: 2] = mode; // [R9]
            rd_value[CTRL_OE_BIT] = out_en;
        end else if (i_paddr == OFS_PERIOD) begin
            rd_value[VAL_W-1:0] = period_sh;
        end else if (i_paddr == OFS_DEAD) begin
            rd_value[VAL_W-1:0] = dead_sh;
        end else if (i_paddr == OFS_OPTION) begin
            rd_value[OPTION_W-1:0] = option_sh;
        end else if (i_paddr == OFS_SET_FIRST) begin
            rd_value[VAL_W-1:0] = set_value[0];
        end else if (i_paddr == OFS_SET_SECOND) begin
            rd_value[VAL_W-1:0] = set_value[1];
        end else if (i_paddr == OFS_SET_THIRD) begin
            rd_value[VAL_W-1:0] = set_value[2];
        end else if (i_paddr == OFS_TRIG0) begin
            rd_value[VAL_W-1:0] = trig_sh[0];
        end else if (i_paddr == OFS_TRIG1) begin
            rd_value[VAL_W-1:0] = trig_sh[1];
        end else if (i_paddr == OFS_ADC_TIMING) begin
            rd_value[ADC_TIMING_W-1:0] = adc_timing;
        end else if (i_paddr == OFS_INT_STATUS) begin
            rd_value[INT_W-1:0] = int_status;
        end else if (i_paddr == OFS_INT_ENABLE) begin
            rd_value[INT_W-1:0] = int_enable;
        end else if (i_paddr == OFS_INT_CLEAR) begin
            rd_value = '0;
        end else if (i_paddr == OFS_STATE) begin
            rd_value[CNT_W-1:0] = cnt;
            rd_value[STATE_DIR_BIT] = dir_up;
            rd_value[STATE_PEND_BIT] = reload_pending;
        end else if (i_paddr == OFS_CMP_U) begin
            rd_value[CNT_W-1:0] = phase_compare[0]; // [R3]
        end else if (i_paddr == OFS_CMP_V) begin
            rd_value[CNT_W-1:0] = phase_compare[1]; // [R3]
        end else if (i_paddr == OFS_CMP_W) begin
            rd_value[CNT_W-1:0] = phase_compare[2]; // [R3]
        end else begin
            hit = 1'b0;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_prdata <= '0;
        end else if (i_psel && !i_penable) begin
            o_prdata <= i_pwrite ? '0 : rd_value;
        end
    end
    // Control and shadow registers.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode <= MODE_DIRECT;
            out_en <= 1'b0;
            period_sh <= RST_PERIOD;
            dead_sh <= RST_DEAD;
            option_sh <= '0;
            adc_timing <= RST_ADC_TIMING;
            for (int p = 0; p < PHASES; p++) begin
                set_value[p] <= '0;
            end
            for (int a = 0; a < ADCS; a++) begin
                trig_sh[a] <= RST_TRIG;
            end
        end else if (wr_en) begin
            if (i_paddr == OFS_CTRL) begin
                mode <= i_pwdata[CTRL_MODE_LSB +: 2]; // [R9]
                out_en <= i_pwdata[CTRL_OE_BIT]; // [R10]
            end else if (i_paddr == OFS_PERIOD) begin
                period_sh <= i_pwdata[VAL_W-1:0];
            end else if (i_paddr == OFS_DEAD) begin
                dead_sh <= i_pwdata[VAL_W-1:0];
            end else if (i_paddr == OFS_OPTION) begin
                option_sh <= i_pwdata[OPTION_W-1:0];
            end else if (i_paddr == OFS_SET_FIRST) begin
                set_value[0] <= i_pwdata[VAL_W-1:0];
            end else if (i_paddr == OFS_SET_SECOND) begin
                set_value[1] <= i_pwdata[VAL_W-1:0];
            end else if (i_paddr == OFS_SET_THIRD) begin
                set_value[2] <= i_pwdata[VAL_W-1:0];
            end else if (i_paddr == OFS_TRIG0) begin
                trig_sh[0] <= i_pwdata[VAL_W-1:0];
            end else if (i_paddr == OFS_TRIG1) begin
                trig_sh[1] <= i_pwdata[VAL_W-1:0];
            end else if (i_paddr == OFS_ADC_TIMING) begin
                adc_timing <= i_pwdata[ADC_TIMING_W-1:0];
            end
        end
    end
    assign o_adc_conv_timing = adc_timing;
    // Sticky event flags; a new event beats a clear in the same cycle.
    logic [INT_W-1:0] flag_set;
    assign flag_set = {fire, valley};
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            int_status <= '0;
            int_enable <= '0;
        end else begin
            if (wr_en && (i_paddr == OFS_INT_ENABLE)) begin
                int_enable <= i_pwdata[INT_W-1:0];
            end
            for (int b = 0; b < INT_W; b++) begin
                if (flag_set[b]) begin
                    int_status[b] <= 1'b1;
                end else if (wr_en && (i_paddr == OFS_INT_CLEAR)
                             && i_pwdata[b]) begin
                    int_status[b] <= 1'b0;
                end
            end
        end
    end
    assign o_irq = |(int_status & int_enable);
endmodule
`default_nettype wire

// >>> test/pwm3_sva.sv
/* Assertion checker for the three-phase PWM top module.
   Assumes one clock domain; it is attached by bind. */
`timescale 1ns/1ps
`default_nettype none
module pwm3_sva import pwm3_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [DATA_W-1:0] i_pwdata,
    input wire logic [DATA_W-1:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [PHASES-1:0] o_pwm_upper,
    input wire logic [PHASES-1:0] o_pwm_lower_n,
    input wire logic [2*PHASES-1:0] o_pwm_oe,
    input wire logic [ADCS-1:0] o_adc_start,
    input wire logic [ADC_TIMING_W-1:0] o_adc_conv_timing,
    input wire logic o_carrier_valley,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    valley_pulse_a: assert property (
        o_carrier_valley |=> !o_carrier_valley) else $error("valley width");
    adc_pulse_a: assert property (
        (o_adc_start & $past(o_adc_start)) == 2'h0) else $error("start width");
    trig_offset_a: assert property (
        o_carrier_valley |-> o_adc_start == 2'h0) else $error("start early");
    arm_overlap_a: assert property (
        (o_pwm_upper & ~o_pwm_lower_n) == 3'h0) else $error("arm overlap");
    upper_gap_a: assert property (
        disable iff (!i_rst_b || !o_pwm_oe[0])
        $fell(o_pwm_upper[0]) |-> o_pwm_lower_n[0] [*2])
        else $error("upper gap");
    lower_gap_a: assert property (
        $rose(o_pwm_lower_n[1]) && $past(o_pwm_oe[4], 4)
        |-> !o_pwm_upper[1] [*2]) else $error("lower gap");
    oe_uniform_a: assert property (
        o_pwm_oe == {6{o_pwm_oe[0]}}) else $error("enables differ");
    disabled_off_a: assert property (
        !o_pwm_oe[0] && !$past(o_pwm_oe[0], 3)
        |-> o_pwm_upper == 3'h0 && o_pwm_lower_n == 3'h0)
        else $error("drive while off");
    timing_hold_a: assert property (
        !$stable(o_adc_conv_timing) |-> $past(i_pwrite) && $past(i_penable))
        else $error("timing moved");
endmodule
`default_nettype wire

// >>> test/pwm3_partner.sv
/* Gate driver and two converters facing the PWM block.
   Assumes the block's clock; a pin floats when not enabled. */
`timescale 1ns/1ps
`default_nettype none
module pwm3_partner import pwm3_pkg::*; #(
    parameter int CONV_CLOCKS = 32
) (
    input wire logic i_clk,
    input wire logic [PHASES-1:0] i_upper,
    input wire logic [PHASES-1:0] i_lower_n,
    input wire logic [2*PHASES-1:0] i_oe,
    input wire logic [ADCS-1:0] i_start,
    output logic o_all_hiz,
    output int o_faults,
    output int o_convs
);
    wire [2*PHASES-1:0] pin;
    int busy [ADCS] = '{0, 0};
    // A released pin floats, so the driver sees no level at all.
    for (genvar k = 0; k < PHASES; k++) begin : g_pin
        assign pin[k] = i_oe[k] ? i_upper[k] : 1'bz;
        assign pin[k+PHASES] = i_oe[k+PHASES] ? !i_lower_n[k] : 1'bz;
    end
    assign o_all_hiz = (pin === {2*PHASES{1'bz}});
    initial begin
        o_faults = 0;
        o_convs = 0;
    end
    always @(posedge i_clk) begin
        // Both switches of one leg on would short the supply.
        for (int k = 0; k < PHASES; k++) begin
            if (pin[k] === 1'b1 && pin[k+PHASES] === 1'b1)
                o_faults++;
        end
        // A start during a conversion is an overrun.
        for (int n = 0; n < ADCS; n++) begin
            if (busy[n] == 1)
                o_convs++;
            if (busy[n] > 0)
                busy[n]--;
            if (i_start[n] === 1'b1) begin
                if (busy[n] > 0)
                    o_faults++;
                busy[n] = CONV_CLOCKS;
            end
        end
    end
endmodule
`default_nettype wire

// >>> test/three_phase_pwm_tb_top.sv
/* Self-checking bench for the three-phase PWM block.
   Assumes the package, the checker and the partner model. */
`timescale 1ns/1ps
`default_nettype none
module three_phase_pwm_tb_top import pwm3_pkg::*; ;
    localparam int P = 49;
    localparam int DT = 5;
    logic i_clk = 0;
    logic i_rst_b = 0;
    logic i_psel = 0;
    logic i_penable = 0;
    logic i_pwrite = 0;
    logic [ADDR_W-1:0] i_paddr = '0;
    logic [DATA_W-1:0] i_pwdata = '0;
    logic [DATA_W-1:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic [PHASES-1:0] o_pwm_upper;
    logic [PHASES-1:0] o_pwm_lower_n;
    logic [2*PHASES-1:0] o_pwm_oe;
    logic [ADCS-1:0] o_adc_start;
    logic [ADC_TIMING_W-1:0] o_adc_conv_timing;
    logic o_carrier_valley;
    logic o_irq;
    logic hiz;
    logic [DATA_W-1:0] rd;
    logic er;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    int faults;
    int convs;
    int cmp [PHASES] = '{800, 800, 800};

    three_phase_pwm dut_u (.*);
    pwm3_partner partner_u (.i_clk(i_clk), .i_upper(o_pwm_upper),
        .i_lower_n(o_pwm_lower_n), .i_oe(o_pwm_oe), .i_start(o_adc_start),
        .o_all_hiz(hiz), .o_faults(faults), .o_convs(convs));

    always #2 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks_done %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do
            @(posedge i_clk);
        while (o_pready !== 1'b1);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, '0);
        check($sformatf("reg %0h", a), rd, exp);
    endtask

    task automatic wait_valley();
        do
            @(posedge i_clk);
        while (o_carrier_valley !== 1'b1);
    endtask

    function automatic int exp_cmp(input logic [1:0] m, input int v,
                                   input int old);
        int c;
        if (m == MODE_LOCK)
            return old;
        c = (m == MODE_DQ) ? (P + 1) / 2 - v : P + 1 - v;
        return c < 0 ? 0 : (c > P + 1 ? P + 1 : c);
    endfunction

    // Counts clocks between two valleys, so the pin lag cancels out.
    task automatic measure(input int t);
        int up [PHASES] = '{0, 0, 0};
        int lo [PHASES] = '{0, 0, 0};
        int at [ADCS] = '{0, 0};
        int n = 0;
        wait_valley();
        do begin
            @(posedge i_clk);
            n++;
            for (int k = 0; k < PHASES; k++) begin
                up[k] += (o_pwm_upper[k] === 1'b1);
                lo[k] += (o_pwm_lower_n[k] === 1'b1);
            end
            for (int k = 0; k < ADCS; k++)
                if (o_adc_start[k] === 1'b1)
                    at[k] = n;
        end while (o_carrier_valley !== 1'b1);
        check("carrier", n, 4 * (P + 1));
        for (int k = 0; k < PHASES; k++) begin
            check("upper", up[k], 4 * (P + 1 - cmp[k]) - 2 * DT);
            check("lower", lo[k], 4 * (P + 1 - cmp[k]) + 2 * DT);
        end
        for (int k = 0; k < ADCS; k++)
            check("trigger", at[k], 2 * t + 1);
    endtask

    task automatic round(input logic [1:0] m, input int v0, input int v1,
                         input int v2, input int t);
        int v [PHASES];
        v = '{v0, v1, v2};
        wait_valley();
        apb(1'b1, OFS_TRIG0, t);
        apb(1'b1, OFS_TRIG1, t);
        apb(1'b1, OFS_CTRL, {29'h0, 1'b1, m});
        apb(1'b1, OFS_SET_SECOND, v1);
        apb(1'b1, OFS_SET_THIRD, v2);
        apb(1'b1, OFS_SET_FIRST, v0);
        apb(1'b0, OFS_STATE, '0);
        check("pending", rd[STATE_PEND_BIT], 1'b1);
        rdc(OFS_CMP_U, cmp[0]);
        for (int k = 0; k < PHASES; k++)
            cmp[k] = exp_cmp(m, v[k], cmp[k]);
        wait_valley();
        measure(t);
        for (int k = 0; k < PHASES; k++)
            rdc(ADDR_W'(OFS_CMP_U + 4 * k), cmp[k]);
    endtask

    initial begin
        void'($urandom(44158));
        repeat (10) @(posedge i_clk);
        i_rst_b <= 1'b1;
        rdc(OFS_CTRL, {30'h0, MODE_DIRECT});
        rdc(OFS_PERIOD, RST_PERIOD);
        rdc(OFS_DEAD, RST_DEAD);
        rdc(OFS_TRIG1, RST_TRIG);
        apb(1'b1, OFS_CMP_U, '0);
        rdc(OFS_CMP_U, RST_PERIOD + 1);
        apb(1'b1, 8'h80, 32'h1);
        check("slverr", er, 1'b1);
        apb(1'b0, 8'h80, '0);
        check("unmapped", rd, '0);
        apb(1'b1, OFS_ADC_TIMING, 32'h0C);
        rdc(OFS_ADC_TIMING, 32'h0C);
        check("conv", o_adc_conv_timing, 6'h0C);
        apb(1'b1, OFS_PERIOD, P);
        apb(1'b1, OFS_DEAD, DT);
        round(MODE_DIRECT, 3, 45, 24, 0);
        repeat (3) begin
            round(MODE_DIRECT, 3 + $urandom % 43, 3 + $urandom % 43,
                  3 + $urandom % 43, $urandom % 40);
            round(MODE_DQ, int'($urandom % 31) - 15, int'($urandom % 31) - 15,
                  int'($urandom % 31) - 15, $urandom % 40);
        end
        round(MODE_LOCK, 1, 2, 3, 7);
        apb(1'b1, OFS_CTRL, {30'h0, MODE_DIRECT});
        wait_valley();
        check("oe", o_pwm_oe, '0);
        check("pins", {o_pwm_upper, o_pwm_lower_n, hiz}, 7'h01);
        apb(1'b1, OFS_INT_CLEAR, 32'h7);
        apb(1'b1, OFS_INT_ENABLE, 32'h1 << INT_VALLEY_BIT);
        wait_valley();
        @(negedge i_clk);
        check("irq", o_irq, 1'b1);
        apb(1'b1, OFS_INT_CLEAR, 32'h1 << INT_VALLEY_BIT);
        @(negedge i_clk);
        check("irq", o_irq, 1'b0);
        apb(1'b1, OFS_INT_ENABLE, '0);
        wait_valley();
        @(negedge i_clk);
        check("irq", o_irq, 1'b0);
        apb(1'b0, OFS_INT_STATUS, '0);
        check("status", rd[INT_VALLEY_BIT], 1'b1);
        check("faults", faults, 0);
        check("convs", convs > 0, 1'b1);
        print_verdict();
    end
endmodule

bind three_phase_pwm pwm3_sva chk_u (.*);
`default_nettype wire
